// ---- reset_standby_defines.vh ----
// offsets, fields, reset values and timing counts of the reset and standby release block
`ifndef RESET_STANDBY_DEFINES_VH
`define RESET_STANDBY_DEFINES_VH

`define ADDR_CTRL 8'h00
`define ADDR_SETTLE_SEL 8'h04
`define ADDR_CAUSE 8'h08
`define ADDR_IRQ_STATUS 8'h0C
`define ADDR_IRQ_MASK 8'h10
`define ADDR_STATE 8'h14

`define CTRL_HALT 0
`define CTRL_STOP 1
`define CTRL_CRYSTAL 2

`define CAUSE_PIN 0
`define CAUSE_WDT 1
`define CAUSE_LVD 2

`define IRQ_HALT_EXIT 0
`define IRQ_STOP_EXIT 1
`define IRQ_RESET_DONE 2

`define CRYSTAL_RESET 1'h0
`define SETTLE_SEL_RESET 2'h0
`define IRQ_MASK_RESET 3'h0
`define CAUSE_RESET 3'h0
`define IRQ_STATUS_RESET 3'h0

`define CLK_PERIOD_NS 10
`define STOP_WAIT_US 34
`define STOP_WAIT_CYCLES ((`STOP_WAIT_US * 1000) / `CLK_PERIOD_NS)
`define PIN_LOW_MIN_US 2
`define PIN_LOW_MIN_CYCLES ((`PIN_LOW_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- settle_counter.v ----
// down counter for oscillator settling waits, paused until oscillation runs
`timescale 1ns/10ps
module settle_counter #(
    parameter WIDTH = 18
) (
    input wire clk,
    input wire reset,
    input wire load,
    input wire [WIDTH-1:0] loadValue,
    input wire countEnable,
    output reg busy,
    output reg done
);
    reg [WIDTH-1:0] count;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= {WIDTH{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                count <= loadValue;
                busy <= 1'b1;
            end else if (busy && countEnable) begin
                if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // settle_counter

// ---- pin_low_filter.v ----
// accepts a reset pin low only after it has stayed low long enough
`timescale 1ns/10ps
module pin_low_filter #(
    parameter MIN_CYCLES = 200,
    parameter WIDTH = 9
) (
    input wire clk,
    input wire reset,
    input wire pinLow,
    output reg accepted
);
    reg [WIDTH-1:0] lowCount;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            lowCount <= {WIDTH{1'b0}};
            accepted <= 1'b0;
        end else if (!pinLow) begin
            lowCount <= {WIDTH{1'b0}};
            accepted <= 1'b0;
        end else if (lowCount >= MIN_CYCLES[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1}) begin
            accepted <= 1'b1;
        end else begin
            lowCount <= lowCount + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule // pin_low_filter

// ---- reset_standby_release.v ----
// reset sequencing, halt and stop standby control with settling waits and apb registers
`timescale 1ns/10ps
`include "reset_standby_defines.vh"
module reset_standby_release #(
    parameter NUM_IRQ = 8,
    parameter CNT_WIDTH = 18,
    parameter SETTLE_0 = 1024,
    parameter SETTLE_1 = 4096,
    parameter SETTLE_2 = 16384,
    parameter SETTLE_3 = 65536
) (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire resetPinN,
    input wire powerOnClear,
    input wire lowVoltageReset,
    input wire watchdogOverflow,
    input wire [NUM_IRQ-1:0] intRequest,
    input wire [NUM_IRQ-1:0] intMask,
    input wire oscRunning,
    input wire [1:0] optionSettleSel,
    input wire optionPinIsPort,
    input wire optionReloaded,
    output reg coreReset,
    output reg cpuClockEnable,
    output reg oscEnable,
    output reg lowSpeedOscEnable,
    output reg lowVoltageDetectorReset,
    output reg watchdogReset,
    output reg irq
);
    localparam ST_RESET = 3'h0;
    localparam ST_RST_SETTLE = 3'h1;
    localparam ST_RUN = 3'h2;
    localparam ST_HALT = 3'h3;
    localparam ST_STOP = 3'h4;
    localparam ST_STOP_SETTLE = 3'h5;
    // stop exit wait as a plain number, cut to the counter width where used
    localparam integer STOP_WAIT = `STOP_WAIT_CYCLES;

    reg [2:0] state;
    reg [2:0] next_state;
    reg crystal;
    reg [1:0] settleTimeSelect;
    reg [2:0] resetCauseFlags;
    reg [2:0] irqStatus;
    reg [2:0] irqMask;
    reg portWindow;
    reg haltPending;
    reg stopPending;
    reg counterLoad;
    reg [CNT_WIDTH-1:0] counterValue;
    reg haltExitEvent;
    reg stopExitEvent;
    reg resetDoneEvent;
    reg [31:0] readWord;

    wire pinAccepted;
    wire counterBusy;
    wire counterDone;
    wire portPinReset;
    wire pinReset;
    wire anyReset;
    wire wakeRequest;
    wire writeAccess;
    wire readSetup;
    wire [2:0] irqEvent;

    function isMapped;
        input [7:0] addr;
        begin
            isMapped = (addr == `ADDR_CTRL) || (addr == `ADDR_SETTLE_SEL) || (addr == `ADDR_CAUSE) ||
                (addr == `ADDR_IRQ_STATUS) || (addr == `ADDR_IRQ_MASK) || (addr == `ADDR_STATE);
        end
    endfunction

    // one decode for the control, cause and status write strobes
    function writeHit;
        input access;
        input [7:0] addr;
        input [7:0] target;
        begin
            writeHit = access && (addr == target);
        end
    endfunction

    function [CNT_WIDTH-1:0] settleCycles;
        input [1:0] sel;
        begin
            if (sel == 2'h0) begin
                settleCycles = SETTLE_0[CNT_WIDTH-1:0];
            end else if (sel == 2'h1) begin
                settleCycles = SETTLE_1[CNT_WIDTH-1:0];
            end else if (sel == 2'h2) begin
                settleCycles = SETTLE_2[CNT_WIDTH-1:0];
            end else begin
                settleCycles = SETTLE_3[CNT_WIDTH-1:0];
            end
        end
    endfunction

    pin_low_filter #(
        .MIN_CYCLES(`PIN_LOW_MIN_CYCLES),
        .WIDTH(9)
    ) pinFilter (
        .clk(clk),
        .reset(reset),
        .pinLow(~resetPinN),
        .accepted(pinAccepted)
    );

    // counter holds its value until the oscillator reports it is running
    settle_counter #(
        .WIDTH(CNT_WIDTH)
    ) settleCounter (
        .clk(clk),
        .reset(reset),
        .load(counterLoad),
        .loadValue(counterValue),
        .countEnable(oscRunning),
        .busy(counterBusy),
        .done(counterDone)
    );

    // port-configured pin resets only inside the window after power-on clear
    assign portPinReset = optionPinIsPort & portWindow & ~resetPinN;
    assign pinReset = optionPinIsPort ? portPinReset : pinAccepted;
    assign anyReset = powerOnClear | lowVoltageReset | watchdogOverflow | pinReset;
    assign wakeRequest = |(intRequest & ~intMask);
    assign writeAccess = psel & penable & pready & pwrite;
    assign readSetup = psel & ~penable & ~pwrite;
    // event bits in the same layout as the status register
    assign irqEvent[`IRQ_HALT_EXIT] = haltExitEvent;
    assign irqEvent[`IRQ_STOP_EXIT] = stopExitEvent;
    assign irqEvent[`IRQ_RESET_DONE] = resetDoneEvent;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            portWindow <= 1'b1;
        end else if (powerOnClear) begin
            portWindow <= 1'b1;
        end else if (optionReloaded) begin
            portWindow <= 1'b0;
        end
    end

    // standby state machine
    always @* begin
        next_state = state;
        counterLoad = 1'b0;
        counterValue = {CNT_WIDTH{1'b0}};
        haltExitEvent = 1'b0;
        stopExitEvent = 1'b0;
        resetDoneEvent = 1'b0;
        if (anyReset) begin
            next_state = ST_RESET;
        end else begin
            case (state)
                ST_RESET: begin
                    next_state = ST_RST_SETTLE;
                    counterLoad = 1'b1;
                    counterValue = settleCycles(optionSettleSel);
                end
                ST_RST_SETTLE: begin
                    if (counterDone) begin
                        next_state = ST_RUN;
                        resetDoneEvent = 1'b1;
                    end
                end
                ST_RUN: begin
                    // stop wins when both requests are pending
                    if (stopPending) begin
                        next_state = ST_STOP;
                    end else if (haltPending && !wakeRequest) begin
                        next_state = ST_HALT;
                    end else if (haltPending) begin
                        haltExitEvent = 1'b1;
                    end
                end
                ST_HALT: begin
                    if (wakeRequest) begin
                        next_state = ST_RUN;
                        haltExitEvent = 1'b1;
                    end
                end
                ST_STOP: begin
                    if (wakeRequest) begin
                        next_state = ST_STOP_SETTLE;
                        counterLoad = 1'b1;
                        if (crystal) begin
                            counterValue = STOP_WAIT[CNT_WIDTH-1:0] + settleCycles(settleTimeSelect);
                        end else begin
                            counterValue = STOP_WAIT[CNT_WIDTH-1:0];
                        end
                    end
                end
                ST_STOP_SETTLE: begin
                    if (counterDone) begin
                        next_state = ST_RUN;
                        stopExitEvent = 1'b1;
                    end
                end
                default: begin
                    next_state = ST_RESET;
                end
            endcase
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_RESET;
            coreReset <= 1'b1;
            cpuClockEnable <= 1'b0;
            oscEnable <= 1'b0;
            lowSpeedOscEnable <= 1'b0;
            lowVoltageDetectorReset <= 1'b1;
            watchdogReset <= 1'b1;
        end else begin
            state <= next_state;
            coreReset <= (next_state == ST_RESET) || (next_state == ST_RST_SETTLE);
            cpuClockEnable <= (next_state == ST_RUN);
            // oscillator restarts only once every reset source has gone
            oscEnable <= !anyReset && (next_state != ST_STOP);
            lowSpeedOscEnable <= !anyReset;
            // detector is cleared by every reset source except its own
            lowVoltageDetectorReset <= powerOnClear | watchdogOverflow | pinReset;
            watchdogReset <= anyReset;
        end
    end

    // standby requests stay pending until the state machine takes them or a reset source clears them
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            haltPending <= 1'b0;
            stopPending <= 1'b0;
        end else if (anyReset) begin
            haltPending <= 1'b0;
            stopPending <= 1'b0;
        end else begin
            if (writeHit(writeAccess, paddr, `ADDR_CTRL) && pwdata[`CTRL_HALT]) begin
                haltPending <= 1'b1;
            end else if (state == ST_RUN && !stopPending) begin
                haltPending <= 1'b0;
            end
            if (writeHit(writeAccess, paddr, `ADDR_CTRL) && pwdata[`CTRL_STOP]) begin
                stopPending <= 1'b1;
            end else if (state == ST_RUN) begin
                stopPending <= 1'b0;
            end
        end
    end

    // configuration registers
    // writes to unmapped offsets fall through every branch
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            crystal <= `CRYSTAL_RESET;
            settleTimeSelect <= `SETTLE_SEL_RESET;
            irqMask <= `IRQ_MASK_RESET;
        end else if (writeAccess) begin
            if (paddr == `ADDR_CTRL) begin
                crystal <= pwdata[`CTRL_CRYSTAL];
            end else if (paddr == `ADDR_SETTLE_SEL) begin
                settleTimeSelect <= pwdata[1:0];
            end else if (paddr == `ADDR_IRQ_MASK) begin
                irqMask <= pwdata[2:0];
            end
        end
    end

    // reset cause flags, write one to clear, new cause wins over clear
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            resetCauseFlags <= `CAUSE_RESET;
        end else if (powerOnClear) begin
            resetCauseFlags <= `CAUSE_RESET;
        end else begin
            resetCauseFlags[`CAUSE_PIN] <= pinReset | (resetCauseFlags[`CAUSE_PIN] &
                ~(writeHit(writeAccess, paddr, `ADDR_CAUSE) && pwdata[`CAUSE_PIN]));
            resetCauseFlags[`CAUSE_WDT] <= watchdogOverflow | (resetCauseFlags[`CAUSE_WDT] &
                ~(writeHit(writeAccess, paddr, `ADDR_CAUSE) && pwdata[`CAUSE_WDT]));
            resetCauseFlags[`CAUSE_LVD] <= lowVoltageReset | (resetCauseFlags[`CAUSE_LVD] &
                ~(writeHit(writeAccess, paddr, `ADDR_CAUSE) && pwdata[`CAUSE_LVD]));
        end
    end

    // sticky interrupt status, set wins over write-one clear
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            irqStatus <= `IRQ_STATUS_RESET;
            irq <= 1'b0;
        end else begin
            irqStatus <= irqEvent |
                (irqStatus & ~(writeHit(writeAccess, paddr, `ADDR_IRQ_STATUS) ? pwdata[2:0] : 3'h0));
            // level output follows the masked sticky bits a cycle later
            irq <= |(irqStatus & irqMask);
        end
    end

    // register read mux, taken into prdata in the setup cycle
    always @* begin
        readWord = 32'h00000000;
        // cause flags are only ever returned as a whole word
        if (paddr == `ADDR_CTRL) begin
            readWord = {29'h0, crystal, stopPending, haltPending};
        end else if (paddr == `ADDR_SETTLE_SEL) begin
            readWord = {30'h0, settleTimeSelect};
        end else if (paddr == `ADDR_CAUSE) begin
            readWord = {29'h0, resetCauseFlags};
        end else if (paddr == `ADDR_IRQ_STATUS) begin
            readWord = {29'h0, irqStatus};
        end else if (paddr == `ADDR_IRQ_MASK) begin
            readWord = {29'h0, irqMask};
        end else if (paddr == `ADDR_STATE) begin
            readWord = {27'h0, counterBusy, portWindow, state};
        end
    end

    // apb slave, no wait states, data latched in the setup cycle
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~isMapped(paddr);
            if (readSetup) begin
                prdata <= readWord;
            end
        end
    end
endmodule // reset_standby_release

// ---- reset_standby_checker.sv ----
// port assertions for the reset and standby release block
`timescale 1ns/10ps
module reset_standby_checker #(
    parameter NUM_IRQ = 8
) (
    input wire clk,
    input wire reset,
    input wire resetPinN,
    input wire powerOnClear,
    input wire lowVoltageReset,
    input wire watchdogOverflow,
    input wire [NUM_IRQ-1:0] intRequest,
    input wire [NUM_IRQ-1:0] intMask,
    input wire oscRunning,
    input wire coreReset,
    input wire cpuClockEnable,
    input wire oscEnable,
    input wire lowSpeedOscEnable,
    input wire lowVoltageDetectorReset,
    input wire watchdogReset
);
    localparam int STOP_MIN = 3400;
    localparam int STOP_MAX = 3520;
    reg [12:0] waitCnt;
    reg fromStop;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // cycles since oscillator restart with the core clock still off
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            waitCnt <= 13'h0000;
            fromStop <= 1'b0;
        end else begin
            waitCnt <= (cpuClockEnable || !oscEnable) ? 13'h0000 : waitCnt + 13'h0001;
            if (cpuClockEnable || coreReset)
                fromStop <= 1'b0;
            else if (!oscEnable)
                fromStop <= 1'b1;
        end
    end
    osc_reset_stop_a: assert property (
        (powerOnClear || lowVoltageReset || watchdogOverflow) |-> ##[1:2] (!lowSpeedOscEnable && !oscEnable))
        else $error("oscillator on in reset");
    core_clk_gate_a: assert property (coreReset |-> !cpuClockEnable)
        else $error("core clock in reset");
    wdt_self_reset_a: assert property (watchdogOverflow |-> ##[1:2] watchdogReset)
        else $error("watchdog not reset");
    lvd_state_keep_a: assert property (
        (lowVoltageReset && !powerOnClear && !watchdogOverflow && resetPinN) [*3] |-> !lowVoltageDetectorReset)
        else $error("detector reset by itself");
    pin_release_a: assert property ($fell(coreReset) |-> resetPinN && $past(resetPinN))
        else $error("reset left with pin low");
    stop_wake_a: assert property (!oscEnable && !coreReset && |(intRequest & ~intMask) |-> ##[1:2] oscEnable)
        else $error("stop kept on interrupt");
    osc_start_wait_a: assert property (!oscRunning && !cpuClockEnable |=> !cpuClockEnable)
        else $error("clock before oscillation");
    stop_wait_len_a: assert property (
        $rose(cpuClockEnable) && fromStop |-> waitCnt >= STOP_MIN && waitCnt <= STOP_MAX)
        else $error("stop wait length wrong");
endmodule // reset_standby_checker

// ---- reset_irq_source.sv ----
// model of reset pin driver, interrupt sources and oscillator start-up
`timescale 1ns/10ps
module reset_irq_source #(
    parameter NUM_IRQ = 8,
    parameter OSC_DELAY = 40
) (
    input wire clk,
    input wire oscEnable,
    output reg resetPinN,
    output reg [NUM_IRQ-1:0] intRequest,
    output reg [NUM_IRQ-1:0] intMask,
    output reg oscRunning
);
    int startCnt = 0;
    initial begin
        resetPinN = 1'b1;
        intRequest = '0;
        intMask = '1;
        oscRunning = 1'b0;
    end
    // oscillation starts some cycles after enable
    always @(posedge clk) begin
        startCnt <= oscEnable ? startCnt + 1 : 0;
        oscRunning <= oscEnable && startCnt >= OSC_DELAY;
    end
    task automatic pinLow(input int cycles);
        @(posedge clk);
        resetPinN <= 1'b0;
        repeat (cycles) @(posedge clk);
        resetPinN <= 1'b1;
    endtask
    task automatic raise(input logic [NUM_IRQ-1:0] req, input logic [NUM_IRQ-1:0] mask);
        @(posedge clk);
        intRequest <= req;
        intMask <= mask;
    endtask
endmodule // reset_irq_source

// ---- tb.sv ----
// self-checking bench for the reset and standby release block
`timescale 1ns/10ps
`include "reset_standby_defines.vh"
module tb;
    localparam int OSC = 40;
    localparam int SET[4] = '{8, 24, 40, 56};
    typedef struct {string what; logic [32:0] value;} note_t;
    note_t notes[$];
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic powerOnClear = 1'b0;
    logic lowVoltageReset = 1'b0;
    logic watchdogOverflow = 1'b0;
    logic [1:0] optionSettleSel = 2'h0;
    logic optionPinIsPort = 1'b0;
    logic optionReloaded = 1'b0;
    logic [7:0] pick;
    wire [31:0] prdata;
    wire [7:0] intRequest;
    wire [7:0] intMask;
    wire pready, pslverr, resetPinN, oscRunning, coreReset, cpuClockEnable;
    wire oscEnable, lowSpeedOscEnable, lowVoltageDetectorReset, watchdogReset, irq;
    int numErrors = 0;
    int checks = 0;
    int n;
    int sel;
    always #5 clk = ~clk;
    reset_standby_release #(.SETTLE_0(SET[0]), .SETTLE_1(SET[1]), .SETTLE_2(SET[2]), .SETTLE_3(SET[3])) dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .resetPinN(resetPinN),
        .powerOnClear(powerOnClear), .lowVoltageReset(lowVoltageReset), .watchdogOverflow(watchdogOverflow),
        .intRequest(intRequest), .intMask(intMask), .oscRunning(oscRunning), .optionSettleSel(optionSettleSel),
        .optionPinIsPort(optionPinIsPort), .optionReloaded(optionReloaded), .coreReset(coreReset),
        .cpuClockEnable(cpuClockEnable), .oscEnable(oscEnable), .lowSpeedOscEnable(lowSpeedOscEnable),
        .lowVoltageDetectorReset(lowVoltageDetectorReset), .watchdogReset(watchdogReset), .irq(irq));
    reset_irq_source #(.OSC_DELAY(OSC)) src (.clk(clk), .oscEnable(oscEnable), .resetPinN(resetPinN),
        .intRequest(intRequest), .intMask(intMask), .oscRunning(oscRunning));
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e, input string what);
        notes.push_back('{what, e});
        apb(1'b0, a, 32'h00000000);
    endtask
    task automatic waitRun;
        n = 0;
        while (cpuClockEnable !== 1'b1) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic srcReset(input int which);
        @(posedge clk);
        optionSettleSel <= 2'($urandom % 4);
        {lowVoltageReset, watchdogOverflow, powerOnClear} <= 3'h1 << which;
        repeat (3) @(negedge clk);
        check("slow osc enable", lowSpeedOscEnable, 0);
        check("cpu clock", cpuClockEnable, 0);
        check("watchdog reset", watchdogReset, 1);
        check("detector reset", lowVoltageDetectorReset, which != 2);
        @(posedge clk) {lowVoltageReset, watchdogOverflow, powerOnClear} <= 3'h0;
        waitRun();
        sel = optionSettleSel;
        check("reset settle", n >= OSC + SET[sel] && n <= OSC + 12 + SET[sel], 1);
        $display("source reset %0d test done", which);
    endtask
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
            check(notes[0].what, {pslverr, prdata}, notes[0].value);
            void'(notes.pop_front());
        end
    end
    task automatic testDone;
        $display("checks %0d, mismatches %0d", checks, numErrors);
        if (numErrors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #200000;
        numErrors++;
        testDone();
    end
    initial begin
        void'($urandom(94));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(`ADDR_SETTLE_SEL, 33'h000000000, "settle select");
        rd(`ADDR_IRQ_MASK, 33'h000000000, "irq mask");
        rd(8'h18, 33'h100000000, "unmapped");
        $display("register test done");
        srcReset(1);
        rd(`ADDR_CAUSE, 33'h000000002, "watchdog cause");
        wr(`ADDR_CAUSE, 32'h00000007);
        srcReset(2);
        rd(`ADDR_CAUSE, 33'h000000004, "detector cause");
        optionPinIsPort <= 1'b1;
        srcReset(0);
        rd(`ADDR_CAUSE, 33'h000000000, "cleared cause");
        fork src.pinLow(30); join_none
        repeat (6) @(negedge clk);
        check("port reset", coreReset, 1);
        repeat (20) @(negedge clk);
        check("port reset held", coreReset, 1);
        waitRun();
        @(posedge clk) optionReloaded <= 1'b1;
        @(posedge clk) optionReloaded <= 1'b0;
        fork src.pinLow(30); join_none
        repeat (12) @(negedge clk);
        check("closed port window", coreReset, 0);
        repeat (30) @(negedge clk);
        @(posedge clk) optionPinIsPort <= 1'b0;
        $display("port pin test done");
        pick = 8'h01 << ($urandom % 8);
        wr(`ADDR_IRQ_MASK, 32'h00000007);
        wr(`ADDR_IRQ_STATUS, 32'h00000007);
        src.raise(pick, pick);
        wr(`ADDR_CTRL, 32'h00000001);
        repeat (4) @(negedge clk);
        check("masked wake", cpuClockEnable, 0);
        check("quiet irq", irq, 0);
        src.raise(pick, 8'h00);
        repeat (3) @(negedge clk);
        check("halt wake", cpuClockEnable, 1);
        wr(`ADDR_CTRL, 32'h00000001);
        repeat (3) @(negedge clk);
        check("halt refused", cpuClockEnable, 1);
        check("irq raised", irq, 1);
        rd(`ADDR_IRQ_STATUS, 33'h000000001, "halt exit status");
        wr(`ADDR_IRQ_STATUS, 32'h00000001);
        repeat (2) @(negedge clk);
        check("irq cleared", irq, 0);
        $display("halt test done");
        src.raise(pick, 8'hFF);
        sel = $urandom % 4;
        wr(`ADDR_SETTLE_SEL, sel);
        wr(`ADDR_CTRL, 32'h00000006);
        repeat (6) @(negedge clk);
        check("stopped oscillator", oscEnable, 0);
        src.raise(pick, 8'h00);
        waitRun();
        check("stop wait", n >= 3400 + OSC + SET[sel] && n <= 3412 + OSC + SET[sel], 1);
        rd(`ADDR_IRQ_STATUS, 33'h000000002, "stop exit status");
        src.raise(pick, 8'hFF);
        wr(`ADDR_CTRL, 32'h00000002);
        repeat (6) @(negedge clk);
        check("oscillator off", oscEnable, 0);
        src.raise(pick, 8'h00);
        waitRun();
        check("plain stop wait", n >= 3400 + OSC && n <= 3412 + OSC, 1);
        $display("stop test done");
        wr(`ADDR_CAUSE, 32'h00000007);
        fork src.pinLow(100); join_none
        repeat (110) @(negedge clk);
        check("short pin pulse", coreReset, 0);
        fork src.pinLow(260); join_none
        repeat (230) @(negedge clk);
        check("pin reset", coreReset, 1);
        waitRun();
        rd(`ADDR_CAUSE, 33'h000000001, "pin cause");
        $display("pin test done");
        testDone();
    end
endmodule // tb
bind reset_standby_release reset_standby_checker #(.NUM_IRQ(NUM_IRQ)) chk (.clk(clk), .reset(reset),
    .resetPinN(resetPinN), .powerOnClear(powerOnClear), .lowVoltageReset(lowVoltageReset),
    .watchdogOverflow(watchdogOverflow), .intRequest(intRequest), .intMask(intMask), .oscRunning(oscRunning),
    .coreReset(coreReset), .cpuClockEnable(cpuClockEnable), .oscEnable(oscEnable),
    .lowSpeedOscEnable(lowSpeedOscEnable), .lowVoltageDetectorReset(lowVoltageDetectorReset),
    .watchdogReset(watchdogReset));
